// File: core/sspmc_pkg.sv
// Package: register map, field positions, mode codes and divider constants
package sspmc_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on APB)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_BUFFER = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;

  // ****************************************************************
  // Field positions of control register one
  // ****************************************************************
  localparam int POS_OVERRUN = 6;
  localparam int POS_PORT_EN = 5;
  localparam int POS_CLK_REL = 4;
  localparam int POS_MODE_LO = 0;
  localparam int MODE_W = 4;

  // ****************************************************************
  // Field positions of control register two
  // ****************************************************************
  localparam int POS_GENERAL_CALL_ENABLE = 7;
  localparam int POS_ACK_STAT = 6;
  localparam int POS_ACK_DATA = 5;
  localparam int SEQ_W = 5;

  // ****************************************************************
  // Operating mode codes
  // ****************************************************************
  localparam logic [3:0] M_SPI_DIV4 = 4'h0;
  localparam logic [3:0] M_SPI_DIV16 = 4'h1;
  localparam logic [3:0] M_SPI_DIV64 = 4'h2;
  localparam logic [3:0] M_SPI_TMR = 4'h3;
  localparam logic [3:0] M_SPI_SLV_SS = 4'h4;
  localparam logic [3:0] M_SPI_SLV = 4'h5;
  localparam logic [3:0] M_I2C_SLV7 = 4'h6;
  localparam logic [3:0] M_I2C_SLV10 = 4'h7;
  localparam logic [3:0] M_I2C_MST = 4'h8;
  localparam logic [3:0] M_SPI_RELOAD = 4'hA;
  localparam logic [3:0] M_I2C_FW = 4'hB;
  localparam logic [3:0] M_I2C_SLV7_SP = 4'hE;
  localparam logic [3:0] M_I2C_SLV10_SP = 4'hF;

  // ****************************************************************
  // Half periods of the serial clock, in system clock cycles
  // ****************************************************************
  localparam int CLK_W = 10;
  localparam logic [9:0] HALF_DIV4 = 10'h002;
  localparam logic [9:0] HALF_DIV16 = 10'h008;
  localparam logic [9:0] HALF_DIV64 = 10'h020;

  // Clock source selected for the baud generator
  typedef enum logic [2:0] {
    SSPMC_SRC_FIXED = 3'b001,
    SSPMC_SRC_TIMER = 3'b010,
    SSPMC_SRC_RELOAD = 3'b100
  } sspmc_src_t;

endpackage : sspmc_pkg

// File: core/sspmc_baud_gen.sv
// Baud generator: serial clock from fixed divide, timer match or reload
`timescale 1ns/1ps
`default_nettype none
module sspmc_baud_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire sspmc_pkg::sspmc_src_t src,
  input wire logic [sspmc_pkg::CLK_W-1:0] fixed_half,
  input wire logic [7:0] reload,
  input wire logic timer_match,
  output logic clk_out
);
  import sspmc_pkg::*;

  logic [CLK_W-1:0] cnt_q;
  logic [CLK_W-1:0] cnt_d;
  logic clk_q;
  logic clk_d;
  logic [CLK_W-1:0] half_len;
  logic tick;

  // Reload mode: period 4*(reload+1), so half period 2*(reload+1)
  assign half_len = (src == SSPMC_SRC_RELOAD) ?
    CLK_W'({1'b0, reload, 1'b0} + 10'h002) : fixed_half;
  // Timer mode toggles per match, giving match rate over two
  assign tick = (src == SSPMC_SRC_TIMER) ? timer_match :
    (cnt_q == half_len - 10'h001);
  assign cnt_d = (!run || tick || src == SSPMC_SRC_TIMER) ? '0 :
    cnt_q + 10'h001;
  assign clk_d = run ? (clk_q ^ tick) : 1'b0;

  // Counter and clock flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign clk_out = clk_q;

endmodule : sspmc_baud_gen
`default_nettype wire

// File: core/sspmc_top.sv
// Mode select, control and status logic of the serial port, APB slave
//
// Overview of operation
// R1 - SPI slave byte into full buffer sets overrun, new byte dropped
// R2 - Overrun never set in SPI master operation
// R3 - Software reads buffer after each SPI slave transfer
// R4 - Overrun flag stays set until software clears it
// R5 - I2C receive into full buffer sets overrun; meaningless in transmit
// R6 - I2C slave: clear clock release holds clock low; set releases
// R7 - Codes 0,1,2 are SPI master at clock divided by 4,16,64
// R8 - Code 3 is SPI master at half the second timer match rate
// R9 - Code 10 is SPI master at clock over 4*(reload+1)
// R10 - Software avoids reload 0 in reload SPI master mode
// R11 - Codes 4,5 are SPI slave with select gating on or off
// R12 - Codes 6,7 are I2C slave 7/10-bit address, no start/stop events
// R13 - Codes 14,15 are I2C slave 7/10-bit with start/stop events
// R14 - Code 8 is I2C master at clock over 4*(reload+1)
// R15 - Software avoids reload 0, 1, 2 in I2C modes
// R16 - Code 11 is firmware I2C master with address matching idle
// R17 - Software avoids reserved codes 9, 12, 13
// R18 - General call enable raises event on address 00h in slave mode
// R19 - Sequence bits and buffer writes only while I2C logic idle
// R20 - Master receive acknowledge slot drives the ack data value
// R21 - Ack status updated after each master transmitted byte
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sspmc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck_pin,
  input wire logic timer_match,
  input wire logic byte_done,
  input wire logic [7:0] shift_byte,
  input wire logic i2c_receiving,
  input wire logic addr_phase,
  input wire logic i2c_idle,
  input wire logic [sspmc_pkg::SEQ_W-1:0] seq_done,
  input wire logic tx_ack_sampled,
  input wire logic peer_nack,
  input wire logic ack_slot,
  output logic [7:0] tx_data,
  output logic tx_load,
  output logic master_clk,
  output logic sck_sync,
  output logic spi_slave_sel_en,
  output logic scl_hold_low,
  output logic addr_match_en,
  output logic start_stop_irq_en,
  output logic ten_bit_addr,
  output logic general_call_evt,
  output logic sda_ack_drive,
  output logic sda_ack_oe,
  output logic [sspmc_pkg::SEQ_W-1:0] seq_req
);
  import sspmc_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic overrun_q;
  logic port_en_q;
  logic clk_rel_q;
  logic [MODE_W-1:0] mode_q;
  logic general_call_enable_q;
  logic ack_stat_q;
  logic ack_data_q;
  logic [SEQ_W-1:0] seq_q;
  logic [7:0] baud_q;
  logic [7:0] rx_buf_q;
  logic buf_full_q;
  logic [7:0] tx_data_q;
  logic tx_load_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic sck_s1_q;
  logic sck_s2_q;
  logic sck_s3_q;
  logic sck_lvl_q;
  logic sel_en_q;
  logic hold_q;
  logic amatch_q;
  logic sp_irq_q;
  logic ten_q;
  logic gc_evt_q;
  logic ack_drv_q;
  logic ack_oe_q;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire is_spi_fixed = (mode_q == M_SPI_DIV4) || (mode_q == M_SPI_DIV16) ||
    (mode_q == M_SPI_DIV64); // [R7]
  wire is_spi_tmr = (mode_q == M_SPI_TMR); // [R8]
  wire is_spi_rel = (mode_q == M_SPI_RELOAD); // [R9]
  wire is_spi_mst = is_spi_fixed || is_spi_tmr || is_spi_rel;
  wire is_spi_slv = (mode_q == M_SPI_SLV_SS) || (mode_q == M_SPI_SLV);
  wire is_i2c_slv_plain = (mode_q == M_I2C_SLV7) ||
    (mode_q == M_I2C_SLV10); // [R12]
  wire is_i2c_slv_sp = (mode_q == M_I2C_SLV7_SP) ||
    (mode_q == M_I2C_SLV10_SP); // [R13]
  wire is_i2c_slv = is_i2c_slv_plain || is_i2c_slv_sp;
  wire is_i2c_mst = (mode_q == M_I2C_MST); // [R14]
  wire is_i2c_fw = (mode_q == M_I2C_FW); // [R16]
  wire is_i2c = is_i2c_slv || is_i2c_mst || is_i2c_fw;
  wire active = port_en_q;

  // Baud source and fixed half period select
  wire sspmc_src_t src_sel = is_spi_tmr ? SSPMC_SRC_TIMER :
    ((is_spi_rel || is_i2c_mst) ? SSPMC_SRC_RELOAD : SSPMC_SRC_FIXED);
  wire [CLK_W-1:0] fixed_half = (mode_q == M_SPI_DIV16) ? HALF_DIV16 :
    ((mode_q == M_SPI_DIV64) ? HALF_DIV64 : HALF_DIV4); // [R7]
  wire gen_run = active && (is_spi_mst || is_i2c_mst);

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pready_q && pwrite;
  wire rd_en = psel && penable && pready_q && !pwrite;
  wire hit_c1 = (paddr == OFS_CTRL_ONE);
  wire hit_c2 = (paddr == OFS_CTRL_TWO);
  wire hit_buf = (paddr == OFS_BUFFER);
  wire hit_baud = (paddr == OFS_BAUD);
  wire hit_stat = (paddr == OFS_STATUS);
  wire mapped = hit_c1 || hit_c2 || hit_buf || hit_baud || hit_stat;
  wire wr_c1 = wr_en && hit_c1;
  wire wr_c2 = wr_en && hit_c2;
  wire wr_buf = wr_en && hit_buf;
  wire wr_baud = wr_en && hit_baud;
  wire rd_buf = rd_en && hit_buf;

  // Read multiplexer, sampled in the setup cycle
  wire [7:0] c1_view = {1'b0, overrun_q, port_en_q, clk_rel_q, mode_q};
  wire [7:0] c2_view = {general_call_enable_q, ack_stat_q, ack_data_q, seq_q};
  wire [7:0] st_view = {4'h0, sck_lvl_q, is_i2c, buf_full_q, is_spi_mst};
  wire [7:0] rd_mux = hit_c1 ? c1_view : hit_c2 ? c2_view :
    hit_buf ? rx_buf_q : hit_baud ? baud_q : hit_stat ? st_view : 8'h00;

  // ****************************************************************
  // Receive buffer and overrun
  // ****************************************************************
  // Overrun in SPI slave, or I2C while receiving; never SPI master
  wire ovr_mode = is_spi_slv || (is_i2c && i2c_receiving); // [R1] [R2] [R5]
  wire rx_ok = active && byte_done && !(is_i2c && !i2c_receiving);
  wire ovr_set = rx_ok && buf_full_q && ovr_mode; // [R1] [R5]
  wire buf_take = rx_ok && !(buf_full_q && ovr_mode); // [R1]
  // Software may only write zero; set wins over a same-cycle clear
  wire ovr_clr = wr_c1 && !pwdata[POS_OVERRUN];
  wire ovr_d = ovr_set || (overrun_q && !ovr_clr); // [R4]

  // Buffer writes and sequence requests refused while I2C is busy
  wire i2c_busy = is_i2c && !i2c_idle;
  wire buf_wr_ok = wr_buf && !i2c_busy; // [R19]
  wire seq_wr_ok = wr_c2 && is_i2c && !i2c_busy; // [R19]
  wire [SEQ_W-1:0] seq_d = seq_wr_ok ? pwdata[SEQ_W-1:0] :
    (seq_q & ~seq_done);

  // Peer acknowledge after a master transmitted byte
  wire ack_upd = tx_ack_sampled && (is_i2c_mst || is_i2c_fw); // [R21]
  wire ack_stat_d = ack_upd ? peer_nack : ack_stat_q; // [R21]

  // General call: address byte 00h seen in slave mode
  wire gc_hit = active && is_i2c_slv && general_call_enable_q && byte_done && addr_phase &&
    (shift_byte == 8'h00); // [R18]

  // ****************************************************************
  // Pin synchroniser for the external serial clock
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      sck_lvl_q <= 1'b0;
    end else begin
      sck_s1_q <= sck_pin;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      if (sck_s2_q == sck_s3_q) begin
        sck_lvl_q <= sck_s3_q; // Level counts once two stages agree
      end
    end
  end

  // ****************************************************************
  // APB response
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (setup) begin
        prdata_q <= {24'h00_0000, rd_mux};
        pslverr_q <= !mapped;
      end
    end
  end

  // ****************************************************************
  // Control register one
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_q <= RST_CTRL_ONE[POS_OVERRUN];
      port_en_q <= RST_CTRL_ONE[POS_PORT_EN];
      clk_rel_q <= RST_CTRL_ONE[POS_CLK_REL];
      mode_q <= RST_CTRL_ONE[MODE_W-1:0];
    end else begin
      overrun_q <= ovr_d; // [R4]
      if (wr_c1) begin
        port_en_q <= pwdata[POS_PORT_EN];
        clk_rel_q <= pwdata[POS_CLK_REL];
        mode_q <= pwdata[POS_MODE_LO +: MODE_W];
      end
    end
  end

  // ****************************************************************
  // Control register two and baud reload
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_call_enable_q <= RST_CTRL_TWO[POS_GENERAL_CALL_ENABLE];
      ack_stat_q <= RST_CTRL_TWO[POS_ACK_STAT];
      ack_data_q <= RST_CTRL_TWO[POS_ACK_DATA];
      seq_q <= RST_CTRL_TWO[SEQ_W-1:0];
      baud_q <= RST_BAUD;
    end else begin
      ack_stat_q <= ack_stat_d;
      seq_q <= seq_d; // [R19]
      if (wr_c2) begin
        general_call_enable_q <= pwdata[POS_GENERAL_CALL_ENABLE];
        ack_data_q <= pwdata[POS_ACK_DATA];
      end
      if (wr_baud) begin
        baud_q <= pwdata[7:0];
      end
    end
  end

  // ****************************************************************
  // Buffers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_q <= 8'h00;
      buf_full_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_load_q <= 1'b0;
    end else begin
      tx_load_q <= buf_wr_ok && active; // Master transfer starts here
      if (buf_wr_ok) begin
        tx_data_q <= pwdata[7:0];
      end
      if (buf_take) begin
        rx_buf_q <= shift_byte;
      end
      // New byte wins over a same-cycle read
      buf_full_q <= buf_take || (buf_full_q && !rd_buf);
    end
  end

  // ****************************************************************
  // Mode driven outputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_en_q <= 1'b0;
      hold_q <= 1'b0;
      amatch_q <= 1'b0;
      sp_irq_q <= 1'b0;
      ten_q <= 1'b0;
      gc_evt_q <= 1'b0;
      ack_drv_q <= 1'b0;
      ack_oe_q <= 1'b0;
    end else begin
      sel_en_q <= active && (mode_q == M_SPI_SLV_SS); // [R11]
      hold_q <= active && is_i2c_slv && !clk_rel_q; // [R6]
      amatch_q <= active && is_i2c_slv; // [R16]
      sp_irq_q <= active && is_i2c_slv_sp; // [R13]
      ten_q <= (mode_q == M_I2C_SLV10) || (mode_q == M_I2C_SLV10_SP);
      gc_evt_q <= gc_hit; // [R18]
      ack_drv_q <= ack_data_q; // [R20]
      ack_oe_q <= active && (is_i2c_mst || is_i2c_fw) && ack_slot &&
        !ack_data_q; // [R20]
    end
  end

  // ****************************************************************
  // Serial clock generation for master modes
  // ****************************************************************
  sspmc_baud_gen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(gen_run),
    .src(src_sel),
    .fixed_half(fixed_half),
    .reload(baud_q),
    .timer_match(timer_match),
    .clk_out(master_clk)
  ); // [R8] [R9] [R14]

  // ****************************************************************
  // Output connections
  // ****************************************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign tx_data = tx_data_q;
  assign tx_load = tx_load_q;
  assign sck_sync = sck_lvl_q;
  assign spi_slave_sel_en = sel_en_q;
  assign scl_hold_low = hold_q;
  assign addr_match_en = amatch_q;
  assign start_stop_irq_en = sp_irq_q;
  assign ten_bit_addr = ten_q;
  assign general_call_evt = gc_evt_q;
  assign sda_ack_drive = ack_drv_q;
  assign sda_ack_oe = ack_oe_q;
  assign seq_req = seq_q;

endmodule : sspmc_top
`default_nettype wire

// File: bench/sspmc_checker.sv
// Checker: port-level properties of the serial port mode block
`timescale 1ns/1ps
`default_nettype none
module sspmc_checker
  import sspmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic byte_done,
  input wire logic [7:0] shift_byte,
  input wire logic ack_slot,
  input wire logic tx_load,
  input wire logic master_clk,
  input wire logic spi_slave_sel_en,
  input wire logic scl_hold_low,
  input wire logic addr_match_en,
  input wire logic start_stop_irq_en,
  input wire logic ten_bit_addr,
  input wire logic general_call_evt,
  input wire logic sda_ack_drive,
  input wire logic sda_ack_oe
);
  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence bufw_s;
    psel && penable && pwrite && paddr == OFS_BUFFER;
  endsequence
  sequence gcause_s;
    byte_done && shift_byte == 8'h00;
  endsequence
  gc_cause_a: assert property (
    general_call_evt |-> $past(byte_done && shift_byte == 8'h00))
    else $error("general call event without address zero");
  gc_slave_a: assert property (
    general_call_evt |-> addr_match_en)
    else $error("general call event outside slave mode");
  hold_slave_a: assert property (
    scl_hold_low |-> addr_match_en && !spi_slave_sel_en)
    else $error("clock held low outside I2C slave mode");
  sel_mode_a: assert property (
    spi_slave_sel_en |-> !addr_match_en && !ten_bit_addr)
    else $error("select gating mixed with I2C slave outputs");
  irq_slave_a: assert property (
    start_stop_irq_en |-> addr_match_en && !spi_slave_sel_en)
    else $error("start stop events outside I2C slave mode");
  clk_master_a: assert property (
    master_clk |-> !addr_match_en && !spi_slave_sel_en)
    else $error("master clock running in a slave mode");
  load_cause_a: assert property (
    tx_load |-> $past(psel && penable && pwrite && paddr == OFS_BUFFER))
    else $error("transmit load without buffer write");
  ack_oe_a: assert property (
    sda_ack_oe |-> $past(ack_slot) && !sda_ack_drive)
    else $error("data line pulled outside acknowledge slot");
  cover property (bufw_s ##1 tx_load);
  cover property (gcause_s ##1 general_call_evt);
endmodule : sspmc_checker
bind sspmc_top sspmc_checker u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .byte_done,
  .shift_byte, .ack_slot, .tx_load, .master_clk, .spi_slave_sel_en,
  .scl_hold_low, .addr_match_en, .start_stop_irq_en, .ten_bit_addr,
  .general_call_evt, .sda_ack_drive, .sda_ack_oe
);
`default_nettype wire

// File: bench/sspmc_peer.sv
// Partner model: serial bus peer and shifter events
`timescale 1ns/1ps
`default_nettype none
module sspmc_peer (
  input wire logic pclk,
  output var logic sck_pin,
  output var logic timer_match,
  output var logic byte_done,
  output var logic [7:0] shift_byte,
  output var logic i2c_receiving,
  output var logic addr_phase,
  output var logic i2c_idle,
  output var logic [4:0] seq_done,
  output var logic tx_ack_sampled,
  output var logic peer_nack,
  output var logic ack_slot
);
  // ****************************************************************
  // Timer pulses and bus events
  // ****************************************************************
  int tmr_per = 0;
  int cnt = 0;
  initial begin
    {sck_pin, timer_match, byte_done, i2c_receiving} = 4'h0;
    {addr_phase, tx_ack_sampled, peer_nack, ack_slot} = 4'h0;
    shift_byte = 8'hFF;
    seq_done = 5'h00;
    i2c_idle = 1'b1;
  end
  // Free-running match pulse every tmr_per+1 cycles
  always @(posedge pclk) begin
    cnt <= (cnt >= tmr_per) ? 0 : cnt + 1;
    timer_match <= (tmr_per != 0) && (cnt == tmr_per);
  end
  // One received byte; data line shows garbage afterwards
  task automatic send(logic [7:0] b, logic rx, logic adr);
    @(posedge pclk);
    byte_done <= 1'b1;
    shift_byte <= b;
    i2c_receiving <= rx;
    addr_phase <= adr;
    @(posedge pclk);
    byte_done <= 1'b0;
    shift_byte <= ~b;
  endtask : send
  task automatic nack_ev(logic n);
    @(posedge pclk);
    tx_ack_sampled <= 1'b1;
    peer_nack <= n;
    @(posedge pclk);
    tx_ack_sampled <= 1'b0;
    peer_nack <= ~n;
  endtask : nack_ev
  task automatic slot(logic v);
    @(posedge pclk);
    ack_slot <= v;
  endtask : slot
  task automatic pin(logic v);
    @(posedge pclk);
    sck_pin <= v;
  endtask : pin
  task automatic busy(logic v);
    @(posedge pclk);
    i2c_idle <= ~v;
  endtask : busy
  task automatic done(logic [4:0] v);
    @(posedge pclk);
    seq_done <= v;
    @(posedge pclk);
    seq_done <= 5'h00;
  endtask : done
endmodule : sspmc_peer
`default_nettype wire

// File: bench/tb.sv
// Testbench: APB-driven tests of the serial port mode block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sspmc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, last_err, sck_pin, timer_match, byte_done;
  logic i2c_receiving, addr_phase, i2c_idle, tx_ack_sampled, peer_nack;
  logic ack_slot, tx_load, master_clk, sck_sync, spi_slave_sel_en;
  logic scl_hold_low, addr_match_en, start_stop_irq_en, ten_bit_addr;
  logic general_call_evt, sda_ack_drive, sda_ack_oe;
  logic [7:0] shift_byte, tx_data;
  logic [4:0] seq_done, seq_req;
  logic [3:0] m;
  logic [3:0] mt [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA, 4'h8};
  int pt [6] = '{4, 16, 64, 10, 16, 16};
  int errors = 0, checked = 0, gc_n = 0, ld_n = 0, n0, p;
  always #4 pclk = ~pclk;
  sspmc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sck_pin, .timer_match,
    .byte_done, .shift_byte, .i2c_receiving, .addr_phase, .i2c_idle,
    .seq_done, .tx_ack_sampled, .peer_nack, .ack_slot, .tx_data,
    .tx_load, .master_clk, .sck_sync, .spi_slave_sel_en, .scl_hold_low,
    .addr_match_en, .start_stop_irq_en, .ten_bit_addr, .general_call_evt,
    .sda_ack_drive, .sda_ack_oe, .seq_req);
  sspmc_peer u_peer (.pclk, .sck_pin, .timer_match, .byte_done,
    .shift_byte, .i2c_receiving, .addr_phase, .i2c_idle, .seq_done,
    .tx_ack_sampled, .peer_nack, .ack_slot);
  // Pulse counters for one-cycle outputs
  always @(posedge pclk) begin
    if (general_call_evt === 1'b1) gc_n <= gc_n + 1;
    if (tx_load === 1'b1) ld_n <= ld_n + 1;
  end
  // ****************************************************************
  // Access, compare and closing tasks
  // ****************************************************************
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk
  task automatic period(output int per);
    logic pv;
    int n, s;
    pv = master_clk;
    s = -1;
    per = 0;
    for (n = 0; n < 400 && per == 0; n++) begin
      @(posedge pclk);
      if (pv === 1'b0 && master_clk === 1'b1) begin
        if (s >= 0) per = n - s;
        else s = n;
      end
      pv = master_clk;
    end
  endtask : period
  task automatic final_report();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // Watchdog against a hung handshake
  initial begin
    #200000;
    errors++;
    final_report();
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl1", OFS_CTRL_ONE, 32'h0);
    rchk("ctrl2", OFS_CTRL_TWO, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'(last_err), 32'h1);
    // Every mode code, clock release both ways
    for (int i = 0; i < 32; i++) begin
      m = i[3:0];
      if (m inside {9, 12, 13}) continue;
      xfer(1'b1, OFS_CTRL_ONE, {27'h1, i[4], m});
      repeat (2) @(posedge pclk);
      chk("sel_en", 32'(spi_slave_sel_en), 32'(m == 4'h4));
      chk("match", 32'(addr_match_en), 32'(m inside {6, 7, 14, 15}));
      chk("irq_en", 32'(start_stop_irq_en), 32'(m >= 4'hE));
      chk("ten", 32'(ten_bit_addr), 32'(m == 4'h7 || m == 4'hF));
      chk("hold", 32'(scl_hold_low), 32'(m inside {6, 7, 14, 15} && !i[4]));
    end
    // Master clock periods, reload 3 and timer match every 5
    u_peer.tmr_per = 4;
    xfer(1'b1, OFS_BAUD, 32'h3);
    foreach (mt[k]) begin
      xfer(1'b1, OFS_CTRL_ONE, {28'h2, mt[k]});
      period(p);
      chk("period", 32'(p), 32'(pt[k]));
    end
    // Overrun in SPI slave, then SPI master
    xfer(1'b1, OFS_CTRL_ONE, 32'h25);
    u_peer.send(8'h5A, 1'b0, 1'b0);
    u_peer.send(8'hC3, 1'b0, 1'b0);
    rchk("ovr", OFS_CTRL_ONE, 32'h65);
    rchk("buf", OFS_BUFFER, 32'h5A);
    rchk("ovr_keep", OFS_CTRL_ONE, 32'h65);
    xfer(1'b1, OFS_CTRL_ONE, 32'h65);
    rchk("ovr_w1", OFS_CTRL_ONE, 32'h65);
    xfer(1'b1, OFS_CTRL_ONE, 32'h20);
    u_peer.send(8'h11, 1'b0, 1'b0);
    u_peer.send(8'h22, 1'b0, 1'b0);
    rchk("ovr_mst", OFS_CTRL_ONE, 32'h20);
    xfer(1'b0, OFS_BUFFER, 32'h0);
    // I2C receive overrun and transmit bytes
    xfer(1'b1, OFS_CTRL_ONE, 32'h36);
    u_peer.send(8'h33, 1'b1, 1'b0);
    u_peer.send(8'h44, 1'b1, 1'b0);
    rchk("ovr_i2c", OFS_CTRL_ONE, 32'h76);
    rchk("buf_i2c", OFS_BUFFER, 32'h33);
    xfer(1'b1, OFS_CTRL_ONE, 32'h36);
    u_peer.send(8'h55, 1'b0, 1'b0);
    u_peer.send(8'h66, 1'b0, 1'b0);
    rchk("ovr_tx", OFS_CTRL_ONE, 32'h36);
    // General call on and off
    n0 = gc_n;
    xfer(1'b1, OFS_CTRL_TWO, 32'h80);
    u_peer.send(8'h00, 1'b1, 1'b1);
    repeat (2) @(posedge pclk);
    chk("gc_on", 32'(gc_n - n0), 32'h1);
    xfer(1'b1, OFS_CTRL_TWO, 32'h0);
    u_peer.send(8'h00, 1'b1, 1'b1);
    repeat (2) @(posedge pclk);
    chk("gc_off", 32'(gc_n - n0), 32'h1);
    // Master acknowledge slot and peer answer
    xfer(1'b1, OFS_CTRL_ONE, 32'h28);
    u_peer.slot(1'b1);
    repeat (2) @(posedge pclk);
    chk("ack_oe", 32'({sda_ack_oe, sda_ack_drive}), 32'h2);
    u_peer.slot(1'b0);
    xfer(1'b1, OFS_CTRL_TWO, 32'h20);
    u_peer.slot(1'b1);
    repeat (2) @(posedge pclk);
    chk("nack_oe", 32'({sda_ack_oe, sda_ack_drive}), 32'h1);
    u_peer.slot(1'b0);
    u_peer.nack_ev(1'b1);
    rchk("ack_stat1", OFS_CTRL_TWO, 32'h60);
    u_peer.nack_ev(1'b0);
    rchk("ack_stat0", OFS_CTRL_TWO, 32'h20);
    // Requests while the bus logic is busy, then idle
    u_peer.busy(1'b1);
    n0 = ld_n;
    xfer(1'b1, OFS_BUFFER, 32'hA5);
    xfer(1'b1, OFS_CTRL_TWO, 32'h21);
    repeat (2) @(posedge pclk);
    chk("ld_busy", 32'(ld_n - n0), 32'h0);
    chk("seq_busy", 32'(seq_req), 32'h0);
    u_peer.busy(1'b0);
    xfer(1'b1, OFS_BUFFER, 32'hA5);
    xfer(1'b1, OFS_CTRL_TWO, 32'h21);
    repeat (2) @(posedge pclk);
    chk("ld_idle", 32'(ld_n - n0), 32'h1);
    chk("tx_data", 32'(tx_data), 32'hA5);
    chk("seq_idle", 32'(seq_req), 32'h1);
    u_peer.done(5'h01);
    repeat (3) @(posedge pclk);
    chk("seq_clr", 32'(seq_req), 32'h0);
    u_peer.pin(1'b1);
    repeat (5) @(posedge pclk);
    chk("sck", 32'(sck_sync), 32'h1);
    rchk("status", OFS_STATUS, 32'hE);
    final_report();
  end
endmodule : tb
`default_nettype wire
